// File: lnd_fifo.sv
// Small valid/ready FIFO in front of the normaliser pipeline
`timescale 1ns/1ps
module lnd_fifo #(
    parameter int W = 22,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        logic [AW:0] wp; // Write pointer with wrap bit
        logic [AW:0] rp; // Read pointer with wrap bit
        logic notFull; // Registered so ready comes straight from a flop
    } lnd_fifo_state_s;

    lnd_fifo_state_s st, next_st;
    logic [W-1:0] mem [DEPTH]; // Storage words
    logic push;
    logic pop;

    assign push = inValid & st.notFull;
    assign pop = outReady & outValid;
    assign inReady = st.notFull;
    assign outValid = st.wp != st.rp;
    assign outData = mem[st.rp[AW-1:0]];

    // Pointer update and full flag
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        // Low in reset, so nothing is accepted until the first edge after it
        next_st.notFull = (next_st.wp[AW-1:0] != next_st.rp[AW-1:0])
            || (next_st.wp[AW] == next_st.rp[AW]);
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Word storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st.wp[AW-1:0]] <= inData;
        end
    end

    a_fifo_noover: assert property (@(posedge core_clk) disable iff (rst) // [RULE_15]
        !st.notFull |=> st.wp == $past(st.wp))
        else $error("FIFO took a word while full");
endmodule : lnd_fifo

// File: lnd_normaliser.sv
// LUT dynamic normaliser with Avalon-MM register port
`timescale 1ns/1ps
module lnd_normaliser
    import lnd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [10:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [31:0] avWritedata,
    input wire logic [3:0] avByteenable,
    output logic [31:0] avReaddata,
    output logic avWaitrequest,
    // Sample input stream
    input wire logic pixValid,
    output logic pixReady,
    input wire logic [XW-1:0] pixData,
    // Result stream
    output logic resValid,
    input wire logic resReady,
    output logic [OW-1:0] resData
);
    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        logic waitreq; // Bus wait, one cycle per access
        logic [31:0] rdata; // Bus read data
        logic dyn; // Dynamic normalisation enable
        logic access; // Table owner: 0 host, 1 pipeline
        logic [4:0] presel; // Lowest bit of prescaler field
        logic [31:0] usat; // Upper saturation value
        logic [31:0] lsat; // Lower saturation value
        logic [15:0] count; // Results delivered
        lnd_s1_s s1;
        lnd_s2_s s2;
        logic rvalid; // Result valid
        logic [OW-1:0] rdat; // Result data
    } lnd_state_s;

    lnd_state_s st, next_st;
    // Table contents are not reset: software must write every entry it uses
    logic [31:0] lut [LUT_DEPTH]; // Table, 32-bit entries [RULE_13]

    //------------------------------------------------------------
    // Input buffer
    //------------------------------------------------------------
    logic fifoValid;
    logic fifoReady;
    logic [XW-1:0] fifoData;
    logic fifoInReady;

    lnd_fifo #(.W(XW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(pixValid),
        .inReady(fifoInReady),
        .inData(pixData),
        .outValid(fifoValid),
        .outReady(fifoReady),
        .outData(fifoData)
    );

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------
    logic req; // Access pending
    logic take; // Access completes this edge
    logic [10:0] wordAddr; // Aligned byte address
    logic isLut; // Access hits the table window
    logic [LUT_AW-1:0] lutIdx; // Table entry addressed by bus
    logic lutWe; // Host table write

    assign req = avRead | avWrite;
    assign take = req & ~st.waitreq;
    assign wordAddr = {avAddress[10:2], 2'b00};
    assign isLut = avAddress[LUT_SEL_BIT];
    assign lutIdx = avAddress[9:2];
    // Host writes the table only while it owns it [RULE_07] [RULE_12]
    assign lutWe = take & avWrite & isLut & ~st.access;

    // Merge enabled byte lanes into an old word
    function automatic logic [31:0] beMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : beMerge

    //------------------------------------------------------------
    // Prescaler
    //------------------------------------------------------------
    logic adv; // Pipeline moves this cycle
    logic pop; // Sample taken from the buffer
    logic signed [XW-1:0] xIn; // Buffered sample
    logic signed [XW-1:0] fieldAll; // Sample shifted to field
    logic signed [XW-1:0] above; // Bits above the field
    logic [FIELD_W-1:0] field; // Selected 8-bit slice
    logic overSel; // Positive value beyond field
    logic underSel; // Negative value below field

    assign xIn = fifoData;
    // A full result that nobody takes halts every stage
    assign adv = ~st.rvalid | resReady;
    // Pipeline takes new samples only while it owns the table [RULE_07]
    assign pop = adv & fifoValid & st.access;
    assign fifoReady = pop;
    assign fieldAll = xIn >>> st.presel;
    // Anything left above the slice means the field overflowed
    assign above = xIn >>> (int'(st.presel) + FIELD_W);
    assign field = fieldAll[FIELD_W-1:0];
    assign overSel = ~xIn[XW-1] & (above != '0); // [RULE_14]
    // Negative input cannot be shown in an unsigned slice
    assign underSel = xIn[XW-1];

    //------------------------------------------------------------
    // Normaliser arithmetic
    //------------------------------------------------------------
    logic signed [OW-1:0] xWide; // Sign-extended sample
    logic signed [OW-1:0] scaled; // Sample after right shifts
    logic [OW-1:0] normOut; // Scaled plus offset

    // Sign extension keeps negative samples negative after the shift
    assign xWide = {{(OW-XW){st.s2.x[XW-1]}}, st.s2.x};
    // Shift count n gives a gradient of 2^-n [RULE_03] [RULE_06]
    assign scaled = xWide >>> st.s2.entry.shift;
    // Offset is the entry's low 22 bits [RULE_04]
    assign normOut = scaled + {{(OW-22){1'b0}}, st.s2.entry.offset};

    //------------------------------------------------------------
    // Read mux for the bus
    //------------------------------------------------------------
    logic [31:0] rdMux;

    // Combinational view of the addressed word, latched on the wait cycle
    always_comb begin
        rdMux = 32'h0000_0000;
        if (isLut) begin
            // Table reads back only while the host owns it
            rdMux = st.access ? 32'h0000_0000 : lut[lutIdx];
        end else begin
            unique case (wordAddr)
                OFF_BCTRL4: rdMux[DYN_BIT] = st.dyn;
                OFF_ACCESS: rdMux[ACC_BIT] = st.access;
                OFF_PRESEL: rdMux[4:0] = st.presel;
                OFF_USAT: rdMux = st.usat;
                OFF_LSAT: rdMux = st.lsat;
                OFF_STATUS: begin
                    rdMux[15:0] = st.count;
                    rdMux[ST_DYN] = st.dyn;
                    rdMux[ST_ACC] = st.access;
                    rdMux[ST_FIFO] = fifoValid;
                end
                default: rdMux = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    // Bus, control words and the three pipeline stages in one place
    always_comb begin
        next_st = st;
        // Bus: one wait cycle, then completion, then back to wait
        if (take) begin
            next_st.waitreq = 1'b1;
        end else if (req) begin
            next_st.waitreq = 1'b0;
            next_st.rdata = rdMux;
        end
        // Control writes land on the completing edge [RULE_12]
        if (take && avWrite && !isLut) begin
            unique case (wordAddr)
                OFF_BCTRL4: begin
                    if (avByteenable[0]) begin
                        next_st.dyn = avWritedata[DYN_BIT]; // [RULE_01]
                    end
                end
                OFF_ACCESS: begin
                    if (avByteenable[0]) begin
                        next_st.access = avWritedata[ACC_BIT]; // [RULE_07]
                    end
                end
                OFF_PRESEL: begin
                    if (avByteenable[0]) begin
                        next_st.presel = avWritedata[4:0]; // [RULE_02]
                    end
                end
                OFF_USAT: begin
                    next_st.usat = beMerge(st.usat, avWritedata, avByteenable);
                end
                OFF_LSAT: begin
                    next_st.lsat = beMerge(st.lsat, avWritedata, avByteenable);
                end
                default: begin
                    // Status and unmapped words ignore writes
                end
            endcase
        end
        // Pipeline, three stages, all held on a stall [RULE_15]
        if (adv) begin
            // Stage 1: prescaler and address
            next_st.s1.valid = pop;
            next_st.s1.x = xIn;
            next_st.s1.dyn = st.dyn; // [RULE_01]
            next_st.s1.over = overSel;
            next_st.s1.under = underSel;
            if (st.dyn) begin
                // Upper six bits of the slice address the table [RULE_02] [RULE_08]
                next_st.s1.addr = {2'b00, field[FIELD_W-1 -: DYN_AW]};
            end else begin
                next_st.s1.addr = field;
            end
            // Stage 2: lookup, saturation replaces the table [RULE_14]
            // Saturation words stand in for the table at its edges
            next_st.s2.valid = st.s1.valid;
            next_st.s2.x = st.s1.x;
            next_st.s2.dyn = st.s1.dyn;
            if (st.s1.over) begin
                next_st.s2.entry = st.usat;
            end else if (st.s1.under) begin
                next_st.s2.entry = st.lsat;
            end else begin
                next_st.s2.entry = lut[st.s1.addr];
            end
            // Stage 3: normaliser or plain lookup result
            next_st.rvalid = st.s2.valid;
            next_st.rdat = st.s2.dyn ? normOut : st.s2.entry; // [RULE_01] [RULE_04]
        end
        if (st.rvalid && resReady) begin
            next_st.count = st.count + 16'h0001;
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            // Bus idles busy so nothing completes during reset
            st.waitreq <= 1'b1;
            st.presel <= PRESEL_RST;
            st.usat <= SAT_RST;
            st.lsat <= SAT_RST;
        end else begin
            st <= next_st;
        end
    end

    // Ready is registered inside the buffer, so it is a flop too
    assign pixReady = fifoInReady;
    assign avReaddata = st.rdata;
    assign avWaitrequest = st.waitreq;
    assign resValid = st.rvalid;
    assign resData = st.rdat;

    //------------------------------------------------------------
    // Table storage, one write lane per byte
    //------------------------------------------------------------
    logic [31:0] lutMerged; // Bus word merged into the old entry

    for (genvar g = 0; g < 4; g++) begin : g_lane
        // Byte 3 is bits 31..24, byte 0 bits 7..0 [RULE_05]
        assign lutMerged[8*g +: 8] = avByteenable[g] ? avWritedata[8*g +: 8]
            : lut[lutIdx][8*g +: 8];
    end

    // One writer for the whole array, so no two processes share it
    // Lanes not enabled write back their old byte unchanged
    always_ff @(posedge core_clk) begin
        if (lutWe) begin
            lut[lutIdx] <= lutMerged;
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Bus handshake and table ownership
    a_bus_one_wait: assert property ( // [RULE_12]
        req && st.waitreq |=> !avWaitrequest ##1 avWaitrequest)
        else $error("Bus access did not finish after one wait");
    a_access_gate: assert property (!st.access |-> !fifoReady) // [RULE_07]
        else $error("Pipeline read table while host owns it");
    a_lut_locked: assert property ( // [RULE_07]
        take && avWrite && isLut && st.access |=> lut[$past(lutIdx)] == $past(lut[lutIdx]))
        else $error("Table changed while pipeline owns it");
    a_lut_bytes: assert property ( // [RULE_05]
        lutWe && avByteenable == 4'hF |=> lut[$past(lutIdx)] == $past(avWritedata))
        else $error("Table word not stored as written");
    // Datapath results
    a_dyn_address: assert property ( // [RULE_08]
        pop && st.dyn && st.presel == 5'h04 && !overSel && !underSel
        |=> st.s1.addr == {2'b00, $past(xIn[11:6])})
        else $error("Dynamic address not bits 6 to 11");
    a_dyn_field: assert property ( // [RULE_02]
        pop && st.dyn && !overSel && !underSel
        |=> st.s1.addr == LUT_AW'(($past(xIn) >> (int'($past(st.presel)) + 2)) & 22'h00003F))
        else $error("Dynamic address not the upper six slice bits");
    a_upper_sat: assert property ( // [RULE_14]
        adv && st.s1.valid && st.s1.over |=> st.s2.entry == $past(st.usat))
        else $error("Overselect did not use upper saturation");
    a_normal_mode: assert property ( // [RULE_01]
        adv && st.s2.valid && !st.s2.dyn |=> resData == $past(st.s2.entry))
        else $error("Normal mode result not the lookup value");
    a_eighth_gain: assert property ( // [RULE_06]
        adv && st.s2.valid && st.s2.dyn && st.s2.entry.shift == 5'h03
        && !st.s2.x[XW-1]
        |=> resData == OW'($past(st.s2.x) / 8) + OW'($past(st.s2.entry.offset)))
        else $error("Shift of three is not one eighth");
    a_unity_offset: assert property ( // [RULE_04]
        adv && st.s2.valid && st.s2.dyn && st.s2.entry.shift == 5'h00
        |=> resData == $past(xWide) + OW'($past(st.s2.entry.offset)))
        else $error("Unity gain result wrong");
    a_fixed_latency: assert property ( // [RULE_15]
        pop ##1 adv [*2] |=> resValid)
        else $error("Result not out three cycles after pop");
    a_stall_hold: assert property ( // [RULE_15]
        resValid && !resReady |=> resValid && $stable(resData))
        else $error("Result dropped or changed while stalled");
    a_count_step: assert property ( // [RULE_15]
        resValid && resReady |=> st.count == $past(st.count) + 16'h0001)
        else $error("Delivered count did not step");

    // Main scenarios worth seeing in every run
    c_dyn_result: cover property (adv && st.s2.valid && st.s2.dyn);
    c_normal_result: cover property (adv && st.s2.valid && !st.s2.dyn);
    c_overselect: cover property (adv && st.s1.valid && st.s1.over);
    c_stall: cover property (resValid && !resReady && fifoValid);
    c_lut_write: cover property (lutWe);
endmodule : lnd_normaliser

// File: lnd_normaliser_test.sv
// Self-checking bench for the LUT dynamic normaliser
`timescale 1ns/1ps
module lnd_normaliser_test
    import lnd_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    typedef struct packed {logic [XW-1:0] x; logic [31:0] y;} lnd_row_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [10:0] avAddress = '0;
    logic avRead = 1'b0;
    logic avWrite = 1'b0;
    logic [31:0] avWritedata = '0;
    logic [3:0] avByteenable = '0;
    logic [31:0] avReaddata;
    logic avWaitrequest;
    logic pixValid;
    logic pixReady;
    logic [XW-1:0] pixData;
    logic resValid;
    logic resReady = 1'b0;
    logic [OW-1:0] resData;
    logic [31:0] q;
    logic [31:0] expQ[$]; // Expected results in order
    lnd_row_s rows [8]; // Dynamic mode cases
    int errors = 0;
    int total_checks = 0;
    int got = 0; // Results taken so far

    always #4 core_clk = ~core_clk;

    lnd_normaliser u_dut (.core_clk(core_clk), .rst(rst), .avAddress(avAddress),
        .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata),
        .avByteenable(avByteenable), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
        .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData), .resValid(resValid),
        .resReady(resReady), .resData(resData));

    lnd_pix_source u_src (.core_clk(core_clk), .rst(rst), .pixValid(pixValid),
        .pixReady(pixReady), .pixData(pixData));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
        total_checks++;
        if (gv !== ev) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, gv, ev);
        end
    endtask : chk

    // One Avalon cycle: hold until waitrequest is seen low at a rising edge
    task automatic avXfer(input logic wr, input logic [10:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        avAddress <= a;
        avWritedata <= d;
        avByteenable <= be;
        avWrite <= wr;
        avRead <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avWaitrequest !== 1'b0 && n < 50);
        rd = avReaddata; // Taken at the completing edge
        avWrite <= 1'b0;
        avRead <= 1'b0;
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
    endtask : avXfer

    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        avXfer(1'b1, a, d, 4'hF, q);
    endtask : wr

    task automatic send(input logic [XW-1:0] x, input logic [31:0] y);
        u_src.push(x);
        expQ.push_back(y);
    endtask : send

    // Bounded wait for n results in total
    task automatic waitRes(input int n);
        int k;
        k = 0;
        while (got < n && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        if (got < n) begin
            errors++;
            print_verdict();
        end
    endtask : waitRes

    // Compare each result as it is taken
    always @(posedge core_clk) begin
        if (!rst && resValid === 1'b1 && resReady === 1'b1) begin
            chk(resData, expQ.pop_front());
            got++;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{22'h0, 32'h0}, '{22'h3F, 32'h3F}, '{22'h40, 32'h40},
            '{22'h3FF, 32'hB7}, '{22'h400, 32'hB8}, '{22'hFFF, 32'hE7},
            '{22'h1000, 32'h1001}, '{22'h3FFFFF, 32'hFFFF_FFFF}};
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        resReady <= 1'b1;
        @(posedge core_clk);
        chk({31'h0, avWaitrequest}, 32'h1);
        // Every register clears on reset
        for (int i = 0; i < 6; i++) begin
            avXfer(1'b0, 11'(i * 4), 32'h0, 4'hF, q);
            chk(q, 32'h0);
        end
        // Entry 1 written one byte lane at a time
        for (int i = 0; i < 4; i++) avXfer(1'b1, 11'h404, 32'h00C0_0038, 4'(1 << i), q);
        avXfer(1'b0, 11'h404, 32'h0, 4'hF, q);
        chk(q, 32'h00C0_0038);
        // Three-segment curve, saturation words, prescaler at bit 4
        for (int n = 0; n < 64; n++)
            wr(11'h400 + 11'(n * 4), n == 0 ? 32'h0 : (n < 16 ? 32'h00C0_0038 : 32'h0180_00A8));
        wr(OFF_USAT, 32'h0000_0001);
        wr(OFF_LSAT, 32'h0040_0000);
        wr(OFF_PRESEL, 32'h4);
        wr(OFF_BCTRL4, 32'h4);
        wr(OFF_ACCESS, 32'h2);
        // Table is closed to the host while the pipeline owns it
        wr(11'h400, 32'hFFFF_FFFF);
        avXfer(1'b0, 11'h400, 32'h0, 4'hF, q);
        chk(q, 32'h0);
        avXfer(1'b0, 11'h018, 32'h0, 4'hF, q);
        chk(q, 32'h0);
        // Dynamic rows: address bits 6..11, shift plus offset, both saturations
        foreach (rows[i]) send(rows[i].x, rows[i].y);
        waitRes(8);
        // Normal lookup returns the whole entry, 8-bit slice as address
        wr(OFF_BCTRL4, 32'h0);
        send(22'h10, 32'h00C0_0038);
        send(22'h100, 32'h0180_00A8);
        waitRes(10);
        // Host owns the table: samples pile up until the buffer refuses
        wr(OFF_BCTRL4, 32'h4);
        wr(OFF_ACCESS, 32'h0);
        for (int i = 0; i < 6; i++) send(22'h40, 32'h40);
        for (int k = 0; k < 300 && pixReady !== 1'b0; k++) @(posedge core_clk);
        chk({31'h0, pixReady}, 32'h0);
        avXfer(1'b0, OFF_STATUS, 32'h0, 4'hF, q);
        chk(q, 32'h0005_000A);
        // Release the table with the sink stalled, then drain
        resReady <= 1'b0;
        wr(OFF_ACCESS, 32'h2);
        repeat (20) @(posedge core_clk);
        chk({31'h0, resValid}, 32'h1);
        resReady <= 1'b1;
        waitRes(16);
        avXfer(1'b0, OFF_STATUS, 32'h0, 4'hF, q);
        chk(q, 32'h0003_0010);
        print_verdict();
    end
endmodule : lnd_normaliser_test

// File: lnd_pix_source.sv
// Upstream sample source model feeding the normaliser input stream
`timescale 1ns/1ps
module lnd_pix_source
    import lnd_pkg::*;
#(
    parameter int GAP = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Sample stream towards the block
    output logic pixValid,
    input wire logic pixReady,
    output logic [XW-1:0] pixData
);
    // ----------------------------------------
    // Pending samples and pacing
    // ----------------------------------------
    logic [XW-1:0] sampleQ[$]; // Samples waiting to be offered
    int idle; // Idle cycles left before the next offer

    // Queue a sample from the bench
    task automatic push(input logic [XW-1:0] s);
        sampleQ.push_back(s);
    endtask : push

    initial begin
        pixValid = 1'b0;
        pixData = '0;
        idle = 0;
    end

    // Offer one sample, hold it until taken, then rest GAP cycles
    always @(posedge core_clk) begin
        if (rst) begin
            pixValid <= 1'b0;
            idle = 0;
        end else if (pixValid && pixReady) begin
            sampleQ.delete(0);
            pixValid <= 1'b0;
            pixData <= ~pixData; // No stale value once released
            idle = GAP; // Keeps the source near 16 MHz at 125 MHz
        end else if (!pixValid && idle > 0) begin
            idle--;
            pixData <= ~pixData; // Data wobbles while idle
        end else if (!pixValid && sampleQ.size() > 0) begin
            pixValid <= 1'b1;
            pixData <= sampleQ[0];
        end
    end
endmodule : lnd_pix_source

// File: lnd_pkg.sv
// Constants and carrier types for the LUT dynamic normaliser
//------------------------------------------------------------
// Notes on behaviour
// RULE_01 - Control four bit 2 enables dynamic mode
// RULE_02 - Prescaler takes 6-bit field as address
// RULE_03 - Entry bits 22..26 steer normaliser scaling
// RULE_04 - Output is scaled input plus entry offset
// RULE_05 - Entries are 32 bits, four bytes, byte3 high
// RULE_06 - Scale field counts right shifts, zero unity
// RULE_07 - Access bit 0 host writes, 1 pipeline reads
// RULE_08 - Select bits 4..11 gives address bits 6..11
// RULE_09 - Core has 21 MACs in three sevens
// RULE_10 - Three line delays of 1120 stages each
// RULE_11 - Source keeps samples at or below 20MHz
// RULE_12 - Host configures everything over processor port
// RULE_13 - Table holds 256 entries plus saturation registers
// RULE_14 - Overselect takes output from upper saturation
// RULE_15 - One sample per cycle, fixed latency
//------------------------------------------------------------
package lnd_pkg;
    // Datapath widths
    localparam int XW = 22;
    localparam int OW = 32;
    localparam int FIELD_W = 8;
    localparam int DYN_AW = 6;
    localparam int LUT_DEPTH = 256;
    localparam int LUT_AW = 8;
    localparam int FIFO_DEPTH = 4;
    // Surrounding core figures, for reference only [RULE_09] [RULE_10]
    localparam int MAC_STAGES = 21;
    localparam int LINE_DELAY = 1120;
    // Fastest sample rate of the source, MHz [RULE_11]
    localparam int MAX_RATE_MHZ = 20;
    // Register byte offsets
    localparam logic [10:0] OFF_BCTRL4 = 11'h000;
    localparam logic [10:0] OFF_ACCESS = 11'h004;
    localparam logic [10:0] OFF_PRESEL = 11'h008;
    localparam logic [10:0] OFF_USAT = 11'h00C;
    localparam logic [10:0] OFF_LSAT = 11'h010;
    localparam logic [10:0] OFF_STATUS = 11'h014;
    localparam int LUT_SEL_BIT = 10;
    // Field positions
    localparam int DYN_BIT = 2;
    localparam int ACC_BIT = 1;
    localparam int SHIFT_LO = 22;
    localparam int ST_DYN = 16;
    localparam int ST_ACC = 17;
    localparam int ST_FIFO = 18;
    // Reset values
    localparam logic [4:0] PRESEL_RST = 5'h00;
    localparam logic [31:0] SAT_RST = 32'h0000_0000;

    // One table entry as seen by the normaliser [RULE_03] [RULE_04]
    typedef struct packed {
        logic [4:0] spare;
        logic [4:0] shift;
        logic [21:0] offset;
    } lnd_entry_s;

    // First pipeline stage: sample plus table address
    typedef struct packed {
        logic valid;
        logic dyn;
        logic over;
        logic under;
        logic [LUT_AW-1:0] addr;
        logic signed [XW-1:0] x;
    } lnd_s1_s;

    // Second pipeline stage: sample plus looked-up entry
    typedef struct packed {
        logic valid;
        logic dyn;
        logic signed [XW-1:0] x;
        lnd_entry_s entry;
    } lnd_s2_s;
endpackage : lnd_pkg
